// File: test/core_model.sv
module core_model (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_irq_req,
   input wire logic [15:0] i_vector_addr,
   input wire logic i_accept,
   input wire logic [1:0] i_delay,
   output logic o_vector_taken,
   output logic [15:0] o_last_vector,
   output int o_n_taken
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_reg;

   // fetches only a requested vector; i_delay models a core busy finishing an instruction
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_vector_taken <= 1'b0;
         wait_reg <= 2'h0;
         o_last_vector <= 16'h0000;
         o_n_taken <= 0;
      end else if (i_irq_req && i_accept && !o_vector_taken) begin
         if (wait_reg == i_delay) begin
            o_vector_taken <= 1'b1;
            o_last_vector <= i_vector_addr;
            o_n_taken <= o_n_taken + 1;
            wait_reg <= 2'h0;
         end else begin
            wait_reg <= wait_reg + 2'h1;
         end
      end else begin
         o_vector_taken <= 1'b0;
      end
   end
endmodule

// File: test/ext_irq_and_vector_map_test.sv
`include "ext_irq_defs.svh"

module ext_irq_and_vector_map_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] rd_dat;
   logic wb_ack;
   logic ext_pin = 1'b1;
   logic [11:0] pc_in = 12'hfff;
   logic global_en = 1'b1;
   logic io_run = 1'b1;
   logic [12:0] periph = 13'h0;
   logic accept = 1'b0;
   logic [1:0] delay = 2'h0;
   logic taken;
   logic irq_req;
   logic [15:0] vec;
   logic wake;
   logic [7:0] mcu;
   logic [15:0] last_vec;
   logic [31:0] rd;
   int n_taken;
   int n_errors = 0;
   int tests_run = 0;
   int base;

   always #20 ref_clk = ~ref_clk;

   ext_irq_and_vector_map u_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_wb_cyc(wb_cyc),
      .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_dat),
      .i_wb_sel(wb_sel), .o_wb_dat(rd_dat), .o_wb_ack(wb_ack), .i_ext_irq_pin(ext_pin),
      .i_pin_change_inputs(pc_in), .i_global_irq_en(global_en), .i_io_clk_run(io_run),
      .i_vector_taken(taken), .i_periph_req(periph), .o_irq_req(irq_req),
      .o_vector_addr(vec), .o_wake_req(wake), .o_mcu_control(mcu));

   core_model u_core (.i_ref_clk(ref_clk), .i_rst(rst), .i_irq_req(irq_req),
      .i_vector_addr(vec), .i_accept(accept), .i_delay(delay), .o_vector_taken(taken),
      .o_last_vector(last_vec), .o_n_taken(n_taken));

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask

   // request held until ack is sampled high; read data taken at that same edge
   task automatic wb(input logic [5:0] idx, input logic w, input logic [7:0] wd);
      int n;
      @(posedge ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= {idx, 2'b00};
      wb_dat <= {24'h0, wd};
      wb_sel <= 4'h1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      rd = rd_dat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (wb_ack !== 1'b1) begin
         check("bus ack", 32'h1, 32'h0);
         test_done();
      end
   endtask

   task automatic rd_chk(input string name, input logic [5:0] idx, input logic [31:0] exp);
      wb(idx, 1'b0, 8'h00);
      check(name, exp, rd);
   endtask

   // 0: irq level, 1: wake level, 2: core take count reaches target
   task automatic wait_for(input int which, input int target);
      int n;
      logic hit;
      for (n = 0; n < 60; n++) begin
         @(posedge ref_clk);
         hit = (which == 0) ? (irq_req === target[0]) :
               (which == 1) ? (wake === target[0]) : (n_taken >= target);
         if (hit) begin
            return;
         end
      end
      check("wait bound", 32'(target), 32'hffff_ffff);
      test_done();
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      idle(4);
      check("vector reset", 32'(`VEC_RESET), 32'(vec));
      rd_chk("mcu_control", `IDX_MCU_CONTROL, 32'h0);
      rd_chk("enables", `IDX_IRQ_ENABLES, 32'h0);
      rd_chk("flags", `IDX_IRQ_FLAGS, 32'h0);
      rd_chk("mask_low", `IDX_PC_MASK_LOW, 32'h0);
      wb(`IDX_MCU_CONTROL, 1'b1, 8'ha5);
      rd_chk("mcu_control", `IDX_MCU_CONTROL, 32'ha5);
      check("mcu_out", 32'ha5, 32'(mcu));
      wb(6'h01, 1'b1, 8'hff);
      rd_chk("unmapped", 6'h01, 32'h0);
      // no source enabled: toggles must not reach the core
      @(posedge ref_clk);
      pc_in <= 12'h000;
      idle(10);
      check("irq idle", 32'h0, 32'(irq_req));
      check("wake idle", 32'h0, 32'(wake));
      @(posedge ref_clk);
      pc_in <= 12'hfff;
      wb(`IDX_PC_MASK_LOW, 1'b1, 8'h01);
      wb(`IDX_IRQ_FLAGS, 1'b1, 8'h70);
      wb(`IDX_IRQ_ENABLES, 1'b1, 8'h10);
      pc_in[1] <= 1'b0;
      idle(10);
      check("irq masked pin", 32'h0, 32'(irq_req));
      accept <= 1'b1;
      delay <= 2'h2;
      base = n_taken;
      pc_in[0] <= 1'b0;
      wait_for(2, base + 1);
      check("vector group0", 32'(`VEC_PC0), 32'(last_vec));
      rd_chk("flags taken", `IDX_IRQ_FLAGS, 32'h0);
      accept <= 1'b0;
      wb(`IDX_PC_MASK_HIGH, 1'b1, 8'h08);
      wb(`IDX_IRQ_ENABLES, 1'b1, 8'h20);
      pc_in[11] <= 1'b0;
      wait_for(0, 1);
      check("vector group1", 32'(`VEC_PC1), 32'(vec));
      rd_chk("flags group1", `IDX_IRQ_FLAGS, 32'h20);
      wb(`IDX_IRQ_FLAGS, 1'b1, 8'h20);
      rd_chk("flags cleared", `IDX_IRQ_FLAGS, 32'h0);
      wait_for(0, 0);
      // change reaches the flag on the very edge the clear write lands
      pc_in[11] <= 1'b1;
      idle(2);
      wb(`IDX_IRQ_FLAGS, 1'b1, 8'h20);
      rd_chk("set beats clear", `IDX_IRQ_FLAGS, 32'h20);
      wb(`IDX_IRQ_FLAGS, 1'b1, 8'h20);
      // wake request does not depend on the global enable
      global_en <= 1'b0;
      wb(`IDX_IRQ_ENABLES, 1'b1, 8'h10);
      pc_in[0] <= 1'b1;
      wait_for(1, 1);
      check("irq without global", 32'h0, 32'(irq_req));
      wb(`IDX_IRQ_FLAGS, 1'b1, 8'h70);
      global_en <= 1'b1;
      wb(`IDX_IRQ_ENABLES, 1'b1, 8'h40);
      wb(`IDX_MCU_CONTROL, 1'b1, 8'h02);
      io_run <= 1'b0;
      ext_pin <= 1'b0;
      idle(10);
      rd_chk("edge while stopped", `IDX_IRQ_FLAGS, 32'h0);
      io_run <= 1'b1;
      ext_pin <= 1'b1;
      idle(10);
      // fall, rise, any change: each toggle of the pin is a triggering edge
      for (int m = 0; m < 3; m++) begin
         wb(`IDX_MCU_CONTROL, 1'b1, (m == 0) ? 8'h02 : (m == 1) ? 8'h03 : 8'h01);
         wb(`IDX_IRQ_FLAGS, 1'b1, 8'h70);
         ext_pin <= ~ext_pin;
         wait_for(0, 1);
         check("vector ext", 32'(`VEC_EXT_IRQ), 32'(vec));
         rd_chk("flags ext", `IDX_IRQ_FLAGS, 32'h40);
         wb(`IDX_IRQ_FLAGS, 1'b1, 8'h40);
         wait_for(0, 0);
      end
      ext_pin <= 1'b1;
      idle(10);
      wb(`IDX_MCU_CONTROL, 1'b1, 8'h00);
      wb(`IDX_IRQ_FLAGS, 1'b1, 8'h70);
      accept <= 1'b1;
      delay <= 2'h0;
      base = n_taken;
      ext_pin <= 1'b0;
      wait_for(2, base + 3);
      check("vector level", 32'(`VEC_EXT_IRQ), 32'(last_vec));
      rd_chk("flags level", `IDX_IRQ_FLAGS, 32'h0);
      accept <= 1'b0;
      ext_pin <= 1'b1;
      wait_for(0, 0);
      // low level gone before the core fetches: no service
      base = n_taken;
      ext_pin <= 1'b0;
      wait_for(0, 1);
      ext_pin <= 1'b1;
      wait_for(0, 0);
      accept <= 1'b1;
      idle(6);
      check("no service", 32'(base), 32'(n_taken));
      accept <= 1'b0;
      wb(`IDX_IRQ_ENABLES, 1'b1, 8'h00);
      for (int i = 0; i < 13; i++) begin
         periph <= 13'h1 << i;
         wait_for(0, 1);
         check("vector periph", 32'h4 + 32'(i), 32'(vec));
         periph <= 13'h0;
         wait_for(0, 0);
      end
      periph <= 13'h1fff;
      wait_for(0, 1);
      idle(3);
      check("vector lowest", 32'(`VEC_WDT), 32'(vec));
      wb(`IDX_IRQ_ENABLES, 1'b1, 8'h40);
      ext_pin <= 1'b0;
      idle(10);
      check("vector ext first", 32'(`VEC_EXT_IRQ), 32'(vec));
      test_done();
   end
endmodule

// File: verilog/ext_irq_and_vector_map.sv
`include "ext_irq_defs.svh"

// Overview of operation
// - resets to word 0, external request word 1
// - pin-change groups at words 2 and 3
// - 16-bit timer events at words 5..8
// - 8-bit timer events at words 9..b
// - remaining sources at their fixed words
// - disabled sources never produce a vector fetch
// - pins interrupt even when driven as outputs
// - enabled toggle on lines 7:0 raises group 0
// - enabled toggle on lines 11:8 raises group 1
// - per-pin masks select participating pin-change inputs
// - pin changes wake from every sleep mode
// - external pin senses fall, rise, any change or low
// - low level requests continuously while held low
// - edges recognised only while I/O clock runs
// - low level wakes without any clock
// - source holds level until start-up completes
// - vanished level resumes after sleep, no service
// - control register at 0x35, eight bits, reset zero
// - sense field: low, any change, fall, rise
// - pin sampled first; long pulses always caught
// - external flag: edge set, take/write clear, level zero
// - group flags: change set, take/write-one clear
module ext_irq_and_vector_map #(
   parameter int PC_LOW_W = `PC_LOW_W,
   parameter int PC_HIGH_W = `PC_HIGH_W,
   parameter int PERIPH_W = `PERIPH_W
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_ext_irq_pin,
   input wire logic [PC_LOW_W+PC_HIGH_W-1:0] i_pin_change_inputs,
   input wire logic i_global_irq_en,
   input wire logic i_io_clk_run,
   input wire logic i_vector_taken,
   input wire logic [PERIPH_W-1:0] i_periph_req,
   output logic o_irq_req,
   output logic [15:0] o_vector_addr,
   output logic o_wake_req,
   output logic [7:0] o_mcu_control
);
   localparam int PC_W = PC_LOW_W + PC_HIGH_W;

   logic ack_reg;
   logic [31:0] rdat_reg;
   logic [31:0] rdat_next;
   logic [7:0] mcu_control_reg;
   logic [7:0] enables_reg;
   logic [PC_LOW_W-1:0] mask_low_reg;
   logic [PC_HIGH_W-1:0] mask_high_reg;
   logic ext_flag_reg;
   logic pc0_flag_reg;
   logic pc1_flag_reg;
   logic ext_prev_reg;
   logic [PC_W-1:0] pc_prev_reg;
   logic irq_reg;
   logic [15:0] vec_reg;
   ext_irq_pkg::src_t taken_src_reg;
   logic wake_reg;

   logic bus_req;
   logic [5:0] reg_idx;
   logic wr_lane0;
   logic [PC_W:0] synced;
   logic ext_stable;
   logic [PC_W-1:0] pc_stable;
   ext_irq_pkg::trig_mode_t mode;
   logic ext_rise;
   logic ext_fall;
   logic ext_edge;
   logic ext_set;
   logic [PC_W-1:0] pc_change;
   logic pc0_set;
   logic pc1_set;
   logic level_req;
   logic clr_ext;
   logic clr_pc0;
   logic clr_pc1;
   logic [15:0] pending;
   logic any_pending;
   ext_irq_pkg::src_t sel_src;
   logic [15:0] sel_vec;

   // bus: one wait state, write lands on the edge that sees ack
   assign bus_req = i_wb_cyc && i_wb_stb;
   assign reg_idx = i_wb_adr[7:2];
   assign wr_lane0 = bus_req && i_wb_we && ack_reg && i_wb_sel[0];

   function automatic logic reg_hit(input logic [5:0] idx, input logic [5:0] want);
      reg_hit = (idx == want);
   endfunction

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req && !ack_reg;
      end
   end

   // unmapped words answer with ack and zero data
   always_comb begin
      rdat_next = `RST_WORD;
      if (reg_hit(reg_idx, `IDX_MCU_CONTROL)) begin
         rdat_next[7:0] = mcu_control_reg;
      end else if (reg_hit(reg_idx, `IDX_IRQ_ENABLES)) begin
         rdat_next[7:0] = enables_reg;
      end else if (reg_hit(reg_idx, `IDX_IRQ_FLAGS)) begin
         rdat_next[`BIT_EXT] = ext_flag_reg && (mode != ext_irq_pkg::TRIG_LOW);
         rdat_next[`BIT_PC1] = pc1_flag_reg;
         rdat_next[`BIT_PC0] = pc0_flag_reg;
      end else if (reg_hit(reg_idx, `IDX_PC_MASK_LOW)) begin
         rdat_next[PC_LOW_W-1:0] = mask_low_reg;
      end else if (reg_hit(reg_idx, `IDX_PC_MASK_HIGH)) begin
         rdat_next[PC_HIGH_W-1:0] = mask_high_reg;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         rdat_reg <= `RST_WORD;
      end else if (bus_req && !ack_reg) begin
         rdat_reg <= rdat_next;
      end
   end

   // control register; only the sense field steers logic here
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         mcu_control_reg <= `RST_REG8;
      end else if (wr_lane0 && reg_hit(reg_idx, `IDX_MCU_CONTROL)) begin
         mcu_control_reg <= i_wb_dat[7:0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         enables_reg <= `RST_REG8;
      end else if (wr_lane0 && reg_hit(reg_idx, `IDX_IRQ_ENABLES)) begin
         enables_reg <= `RST_REG8;
         enables_reg[`BIT_EXT] <= i_wb_dat[`BIT_EXT];
         enables_reg[`BIT_PC1] <= i_wb_dat[`BIT_PC1];
         enables_reg[`BIT_PC0] <= i_wb_dat[`BIT_PC0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         mask_low_reg <= '0;
         mask_high_reg <= '0;
      end else begin
         if (wr_lane0 && reg_hit(reg_idx, `IDX_PC_MASK_LOW)) begin
            mask_low_reg <= i_wb_dat[PC_LOW_W-1:0];
         end
         if (wr_lane0 && reg_hit(reg_idx, `IDX_PC_MASK_HIGH)) begin
            mask_high_reg <= i_wb_dat[PC_HIGH_W-1:0];
         end
      end
   end

   // pad levels are read whatever the pin direction, so writing
   // the port register can raise a software interrupt
   pin_sync #(
      .W(PC_W + 1)
   ) u_pin_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_async({i_ext_irq_pin, i_pin_change_inputs}),
      .o_stable(synced)
   );

   assign ext_stable = synced[PC_W];
   assign pc_stable = synced[PC_W-1:0];
   assign mode = ext_irq_pkg::trig_mode_t'(mcu_control_reg[`FLD_TRIG_HI:`FLD_TRIG_LO]);

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ext_prev_reg <= 1'b1;
         pc_prev_reg <= '1;
      end else begin
         ext_prev_reg <= ext_stable;
         pc_prev_reg <= pc_stable;
      end
   end

   // external pin sensing
   assign ext_rise = ext_stable && !ext_prev_reg;
   assign ext_fall = !ext_stable && ext_prev_reg;

   always_comb begin
      case (mode)
         ext_irq_pkg::TRIG_ANY: ext_edge = ext_rise || ext_fall;
         ext_irq_pkg::TRIG_FALL: ext_edge = ext_fall;
         ext_irq_pkg::TRIG_RISE: ext_edge = ext_rise;
         default: ext_edge = 1'b0;
      endcase
   end

   // prev still tracks while stopped, so a stale edge never fires later
   assign ext_set = ext_edge && i_io_clk_run;
   assign level_req = (mode == ext_irq_pkg::TRIG_LOW) && !ext_stable;

   // pin-change detection, masked per pin
   assign pc_change = pc_stable ^ pc_prev_reg;
   assign pc0_set = |(pc_change[PC_LOW_W-1:0] & mask_low_reg);
   assign pc1_set = |(pc_change[PC_W-1:PC_LOW_W] & mask_high_reg);

   // flag clears: write of one, or the core taking that vector
   assign clr_ext = (wr_lane0 && reg_hit(reg_idx, `IDX_IRQ_FLAGS) && i_wb_dat[`BIT_EXT])
      || (i_vector_taken && irq_reg && taken_src_reg == ext_irq_pkg::SRC_EXT);
   assign clr_pc0 = (wr_lane0 && reg_hit(reg_idx, `IDX_IRQ_FLAGS) && i_wb_dat[`BIT_PC0])
      || (i_vector_taken && irq_reg && taken_src_reg == ext_irq_pkg::SRC_PC0);
   assign clr_pc1 = (wr_lane0 && reg_hit(reg_idx, `IDX_IRQ_FLAGS) && i_wb_dat[`BIT_PC1])
      || (i_vector_taken && irq_reg && taken_src_reg == ext_irq_pkg::SRC_PC1);

   // set beats a clear landing in the same cycle
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         ext_flag_reg <= 1'b0;
      end else if (mode == ext_irq_pkg::TRIG_LOW) begin
         ext_flag_reg <= 1'b0;
      end else begin
         ext_flag_reg <= ext_set || (ext_flag_reg && !clr_ext);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         pc0_flag_reg <= 1'b0;
         pc1_flag_reg <= 1'b0;
      end else begin
         pc0_flag_reg <= pc0_set || (pc0_flag_reg && !clr_pc0);
         pc1_flag_reg <= pc1_set || (pc1_flag_reg && !clr_pc1);
      end
   end

   // a level request exists only while the pin is low; if it is gone
   // by the end of start-up, nothing is pending and the core resumes
   // after its sleep instruction
   assign pending[ext_irq_pkg::SRC_EXT] =
      enables_reg[`BIT_EXT] && (level_req || ext_flag_reg);
   assign pending[ext_irq_pkg::SRC_PC0] = enables_reg[`BIT_PC0] && pc0_flag_reg;
   assign pending[ext_irq_pkg::SRC_PC1] = enables_reg[`BIT_PC1] && pc1_flag_reg;
   assign pending[15:3] = i_periph_req;

   vector_select u_vector_select (
      .i_pending(pending),
      .o_any(any_pending),
      .o_src(sel_src),
      .o_vector(sel_vec)
   );

   // request and vector to the core; the reset word is shown at reset
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         irq_reg <= 1'b0;
         vec_reg <= `VEC_RESET;
         taken_src_reg <= ext_irq_pkg::SRC_EXT;
      end else if (i_vector_taken) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= any_pending && i_global_irq_en;
         if (any_pending) begin
            vec_reg <= sel_vec;
            taken_src_reg <= sel_src;
         end
      end
   end

   // wake ignores the global enable; it only restarts the clocks.
   // the synchroniser costs four cycles once the clock is back.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= |pending[ext_irq_pkg::SRC_PC1:ext_irq_pkg::SRC_EXT];
      end
   end

   assign o_wb_ack = ack_reg;
   assign o_wb_dat = rdat_reg;
   assign o_irq_req = irq_reg;
   assign o_vector_addr = vec_reg;
   assign o_wake_req = wake_reg;
   assign o_mcu_control = mcu_control_reg;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_level_low;
      (mode == ext_irq_pkg::TRIG_LOW && enables_reg[`BIT_EXT] && !ext_stable)[*2];
   endsequence

   sequence s_quiet_core;
      i_global_irq_en && !i_vector_taken;
   endsequence

   AST_RESET_VECTOR: assert property ($fell(i_rst) |-> o_vector_addr == `VEC_RESET)
      else $error("vector not at reset word after reset");

   AST_LEVEL_FLAG_ZERO: assert property (mode == ext_irq_pkg::TRIG_LOW |=> !ext_flag_reg)
      else $error("external flag set in level mode");

   AST_PC0_SET: assert property (
      pc0_set |=> pc0_flag_reg ##1 (pc0_flag_reg || $past(clr_pc0)))
      else $error("group 0 flag missed an enabled change");

   AST_PC1_SET: assert property (pc1_set |=> pc1_flag_reg)
      else $error("group 1 flag missed an enabled change");

   AST_MASKED_IGNORED: assert property (
      !pc0_flag_reg && |pc_change[PC_LOW_W-1:0] && mask_low_reg == '0 |=> !pc0_flag_reg)
      else $error("masked pin change set group 0 flag");

   AST_SET_WINS: assert property (pc1_set && clr_pc1 |=> pc1_flag_reg)
      else $error("clear beat a simultaneous set");

   AST_EDGE_GATED: assert property (!i_io_clk_run && !ext_flag_reg |=> !ext_flag_reg)
      else $error("edge recognised with I/O clock stopped");

   AST_LEVEL_HOLD: assert property (s_level_low ##0 s_quiet_core |=> o_irq_req ##0
      o_vector_addr == `VEC_EXT_IRQ)
      else $error("held low level not requesting external vector");

   AST_LEVEL_WAKE: assert property (level_req && enables_reg[`BIT_EXT] |=> o_wake_req)
      else $error("low level did not raise wake");

   AST_NO_DISABLED_FETCH: assert property (pending == '0 |=> !o_irq_req)
      else $error("request raised with nothing enabled pending");

   AST_LOWEST_FIRST: assert property (pending[ext_irq_pkg::SRC_EXT] ##0 s_quiet_core |=>
      o_vector_addr == `VEC_EXT_IRQ)
      else $error("higher vector served before external request");

   AST_PIN_CHANGE_WAKE: assert property (
      $rose(pc0_flag_reg) && enables_reg[`BIT_PC0] |-> ##1 o_wake_req)
      else $error("pin change did not raise wake");
endmodule

// File: verilog/ext_irq_defs.svh
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH

// register word indices; byte address is four times the index
`define IDX_PC_MASK_LOW 6'h12
`define IDX_PC_MASK_HIGH 6'h20
`define IDX_MCU_CONTROL 6'h35
`define IDX_IRQ_FLAGS 6'h3a
`define IDX_IRQ_ENABLES 6'h3b

`define RST_REG8 8'h00
`define RST_WORD 32'h0000_0000

// bit positions shared by the enable and flag registers
`define BIT_EXT 6
`define BIT_PC1 5
`define BIT_PC0 4

// sense-control field inside mcu_control
`define FLD_TRIG_HI 1
`define FLD_TRIG_LO 0

`define PC_LOW_W 8
`define PC_HIGH_W 4
`define PERIPH_W 13

// program word of each vector
`define VEC_RESET 16'h0000
`define VEC_EXT_IRQ 16'h0001
`define VEC_PC0 16'h0002
`define VEC_PC1 16'h0003
`define VEC_WDT 16'h0004
`define VEC_T16_CAPT 16'h0005
`define VEC_T16_CMPA 16'h0006
`define VEC_T16_CMPB 16'h0007
`define VEC_T16_OVF 16'h0008
`define VEC_T8_CMPA 16'h0009
`define VEC_T8_CMPB 16'h000a
`define VEC_T8_OVF 16'h000b
`define VEC_ANA_CMP 16'h000c
`define VEC_CONV_DONE 16'h000d
`define VEC_EEPROM_RDY 16'h000e
`define VEC_SER_START 16'h000f
`define VEC_SER_OVF 16'h0010

`endif

// File: verilog/ext_irq_pkg.sv
package ext_irq_pkg;
   // field values line up with the two sense-control bits
   typedef enum logic [1:0] {
      TRIG_LOW,
      TRIG_ANY,
      TRIG_FALL,
      TRIG_RISE
   } trig_mode_t;

   // source index, lowest index wins arbitration
   typedef enum logic [3:0] {
      SRC_EXT, SRC_PC0, SRC_PC1, SRC_WDT,
      SRC_T16_CAPT, SRC_T16_CMPA, SRC_T16_CMPB, SRC_T16_OVF,
      SRC_T8_CMPA, SRC_T8_CMPB, SRC_T8_OVF, SRC_ANA_CMP,
      SRC_CONV_DONE, SRC_EEPROM_RDY, SRC_SER_START, SRC_SER_OVF
   } src_t;
endpackage

// File: verilog/pin_sync.sv
module pin_sync #(
   parameter int W = 1
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_stable
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] stable_reg;

   always_ff @(posedge i_ref_clk) begin
      // stages start at the idle-high level so release makes no false edge
      if (i_rst) begin
         s1_reg <= '1;
         s2_reg <= '1;
         s3_reg <= '1;
      end else begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a bit moves only once the two later stages agree
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         stable_reg <= '1;
      end else begin
         stable_reg <= (s2_reg & s3_reg) | (stable_reg & (s2_reg ^ s3_reg));
      end
   end

   assign o_stable = stable_reg;
endmodule

// File: verilog/vector_select.sv
`include "ext_irq_defs.svh"

module vector_select (
   input wire logic [15:0] i_pending,
   output logic o_any,
   output ext_irq_pkg::src_t o_src,
   output logic [15:0] o_vector
);
   function automatic logic [15:0] vec_of(input ext_irq_pkg::src_t s);
      case (s)
         ext_irq_pkg::SRC_EXT: vec_of = `VEC_EXT_IRQ;
         ext_irq_pkg::SRC_PC0: vec_of = `VEC_PC0;
         ext_irq_pkg::SRC_PC1: vec_of = `VEC_PC1;
         ext_irq_pkg::SRC_WDT: vec_of = `VEC_WDT;
         ext_irq_pkg::SRC_T16_CAPT: vec_of = `VEC_T16_CAPT;
         ext_irq_pkg::SRC_T16_CMPA: vec_of = `VEC_T16_CMPA;
         ext_irq_pkg::SRC_T16_CMPB: vec_of = `VEC_T16_CMPB;
         ext_irq_pkg::SRC_T16_OVF: vec_of = `VEC_T16_OVF;
         ext_irq_pkg::SRC_T8_CMPA: vec_of = `VEC_T8_CMPA;
         ext_irq_pkg::SRC_T8_CMPB: vec_of = `VEC_T8_CMPB;
         ext_irq_pkg::SRC_T8_OVF: vec_of = `VEC_T8_OVF;
         ext_irq_pkg::SRC_ANA_CMP: vec_of = `VEC_ANA_CMP;
         ext_irq_pkg::SRC_CONV_DONE: vec_of = `VEC_CONV_DONE;
         ext_irq_pkg::SRC_EEPROM_RDY: vec_of = `VEC_EEPROM_RDY;
         ext_irq_pkg::SRC_SER_START: vec_of = `VEC_SER_START;
         default: vec_of = `VEC_SER_OVF;
      endcase
   endfunction

   // scan from the top so the lowest pending index is left standing
   always_comb begin
      o_any = |i_pending;
      o_src = ext_irq_pkg::SRC_EXT;
      for (int i = 15; i >= 0; i--) begin
         if (i_pending[i]) begin
            o_src = ext_irq_pkg::src_t'(i[3:0]);
         end
      end
      o_vector = vec_of(o_src);
   end
endmodule
